// >>> dv/tb_top.sv
`default_nettype none
module tb_top
    import pwm_evt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // Stimulus and observation
    // ---------------------------------------------------------------
    logic              mclk;
    logic              rst_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
    logic [7:0]        rdata;
    logic              ext_ev;
    logic [3:0]        cmp;
    logic              prd_ev, rise_ev, fall_ev;
    logic              rblank, fblank, dband, pwm;
    logic [15:0]       np, nr, nf, nrb, nfb, ndb, npw;
    int                mismatches;
    int                check_count;
    int                cycles;

    pwm_event_time_base dut (
        .MCLK_I             (mclk),
        .RST_N_I            (rst_n),
        .ADDR_I             (addr),
        .WDATA_I            (wdata),
        .WR_I               (wr),
        .RD_I               (rd),
        .RDATA_O            (rdata),
        .EXT_EVENT_I        (ext_ev),
        .CMP_SYNC_I         (cmp),
        .PERIOD_EVENT_O     (prd_ev),
        .RISE_EVENT_O       (rise_ev),
        .FALL_EVENT_O       (fall_ev),
        .RISE_BLANK_START_O (rblank),
        .FALL_BLANK_START_O (fblank),
        .DEADBAND_START_O   (dband),
        .PWM_O              (pwm)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Ceiling well above the roughly 450 cycles the tests need
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            wrap_up();
        end
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask

    // Pending values only; the load bit is written separately through OFS_CTRL
    task automatic set_cmp(input logic [15:0] pr, input logic [15:0] ph,
                           input logic [15:0] dc);
        wr_reg(OFS_PRL, pr[7:0]);
        wr_reg(OFS_PRH, pr[15:8]);
        wr_reg(OFS_PHL, ph[7:0]);
        wr_reg(OFS_PHH, ph[15:8]);
        wr_reg(OFS_DCL, dc[7:0]);
        wr_reg(OFS_DCH, dc[15:8]);
    endtask

    // Counts high cycles of each output; tog makes a pin rising edge every 2 cycles
    task automatic watch(input int n, input bit tog);
        {np, nr, nf, nrb, nfb, ndb, npw} = '0;
        repeat (n) begin
            @(posedge mclk);
            if (tog) ext_ev <= ~ext_ev;
            #1;
            np  = np  + (prd_ev  === 1'b1);
            nr  = nr  + (rise_ev === 1'b1);
            nf  = nf  + (fall_ev === 1'b1);
            nrb = nrb + (rblank  === 1'b1);
            nfb = nfb + (fblank  === 1'b1);
            ndb = ndb + (dband   === 1'b1);
            npw = npw + (pwm     === 1'b1);
        end
    endtask

    task automatic wait_prd();
        int k;
        k = 0;
        do begin
            @(posedge mclk);
            #1 k = k + 1;
        end while (prd_ev !== 1'b1 && k < 100);
        chk(16'(k < 100), 16'h0001);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {wr, rd, ext_ev, addr, wdata, cmp} = '0;
        rst_n = 1'b0;
        mismatches = 0;
        check_count = 0;
        cycles = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        rd_reg(OFS_PRL, 8'hFF);
        rd_reg(OFS_PRH, 8'hFF);
        rd_reg(OFS_RSRC, 8'h01);
        rd_reg(OFS_FLAGS, 8'h00);
        rd_reg(4'hD, 8'h00);
        $display("test reset done");

        set_cmp(16'h0003, 16'h0001, 16'h0002);
        rd_reg(OFS_PRL, 8'h03);
        wr_reg(OFS_CTRL, 8'h01);
        watch(20, 1'b0);
        chk(np, 16'h0000);
        rd_reg(OFS_TMRH, 8'h00);
        wr_reg(OFS_TMRH, 8'hFF);
        wr_reg(OFS_TMRL, 8'hF0);
        rd_reg(OFS_TMRH, 8'hFF);
        wr_reg(OFS_CTRL, 8'h03);
        wait_prd();
        rd_reg(OFS_CTRL, 8'h01);
        watch(40, 1'b0);
        chk(np, 16'd10);
        chk(nr, 16'd10);
        chk(nf, 16'd10);
        chk(nfb, 16'd10);
        chk(nrb, 16'd10);
        chk(ndb, 16'd20);
        chk(npw, 16'd10);
        rd_reg(OFS_FLAGS, 8'h0E);
        $display("test sync walk done");

        wr_reg(OFS_TMRH, 8'hFF);
        wr_reg(OFS_TMRL, 8'hF0);
        watch(20, 1'b0);
        rd_reg(OFS_FLAGS, 8'h0F);
        $display("test overflow done");

        set_cmp(16'h0003, 16'h0001, 16'h0001);
        wr_reg(OFS_CTRL, 8'h03);
        watch(8, 1'b0);
        watch(40, 1'b0);
        chk(npw, 16'd0);
        chk(nr, 16'd10);
        chk(nf, 16'd10);
        set_cmp(16'h0003, 16'h0001, 16'h0005);
        wr_reg(OFS_CTRL, 8'h03);
        watch(8, 1'b0);
        watch(40, 1'b0);
        chk(nf, 16'd0);
        chk(npw, 16'd40);
        $display("test duty limits done");

        set_cmp(16'h0003, 16'h0001, 16'h0002);
        wr_reg(OFS_RSRC, 8'h03);
        wr_reg(OFS_CTRL, 8'h03);
        watch(8, 1'b1);
        watch(40, 1'b1);
        chk(nr, 16'd10);
        chk(np, 16'd10);
        $display("test rise gating done");

        set_cmp(16'h0007, 16'h0002, 16'h0006);
        wr_reg(OFS_RSRC, 8'h01);
        wr_reg(OFS_FSRC, 8'h05);
        wr_reg(OFS_CTRL, 8'h03);
        watch(16, 1'b0);
        wait_prd();
        @(posedge mclk);
        cmp <= 4'h1;
        watch(8, 1'b0);
        chk(nr, 16'd0);
        chk(nf, 16'd1);
        chk(npw, 16'd0);
        chk(nrb, 16'd1);
        chk(nfb, 16'd0);
        chk(ndb, 16'd1);
        cmp <= 4'h0;
        $display("test fall first done");

        wr_reg(OFS_RSRC, 8'h02);
        wr_reg(OFS_FSRC, 8'h01);
        // Align to a period start so the gated count is fixed
        wait_prd();
        watch(10, 1'b1);
        chk(nr, 16'd2);
        wr_reg(OFS_PSRC, 8'h03);
        watch(10, 1'b1);
        chk(np, 16'd5);
        wr_reg(OFS_CTRL, 8'h00);
        rd_reg(OFS_TMRL, 8'h00);
        rd_reg(OFS_TMRH, 8'h00);
        rd_reg(OFS_FLAGS, 8'h00);
        watch(10, 1'b0);
        chk(np, 16'd0);
        $display("test disable done");
        wrap_up();
    end
endmodule
`default_nettype wire

// >>> pkg/pwm_evt_pkg.sv
// Overview of operation
// - Rising event is any selected mix of phase match, pin and comparators.
// - Only the first rising event of a period acts; later ones ignored.
// - A rising event after a falling event in the period is suppressed.
// - Accepted rising event pulses falling blanking and dead-band starts.
// - Falling event is any selected mix of duty match, pin and comparators.
// - Only the first falling event of a period acts; later ones ignored.
// - A falling event blocks later rising events in the same period.
// - Accepted falling event pulses rising blanking and dead-band starts.
// - Load request applies pending period, phase, duty together at period reset.
// - Counter counts up from zero to all ones, one step per clock.
// - Wrap from all ones to zero without period event sets overflow flag.
// - Every period event, synchronous or asynchronous, resets the counter.
// - Counter, period, phase and duty are read and written as byte pairs.
// - Clearing module enable returns the counter to its reset value.
// - Counter equal to active period value makes period event, sets flag.
// - Compares use shadow copies refreshed only at period reset after load.
// - Period by match alone lasts period value plus one clocks.
// - Counter equal to active phase value makes rising event, sets flag.
// - Counter equal to active duty value makes falling event, sets flag.
// - Duty equal to phase gives coincident events and zero duty output.
// - Duty never matching gives no falling event and full duty output.
// - After a period event counter clears next edge, then counts from zero.
`default_nettype none
package pwm_evt_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL  = 4'h0;
    localparam logic [3:0] OFS_TMRL  = 4'h1;
    localparam logic [3:0] OFS_TMRH  = 4'h2;
    localparam logic [3:0] OFS_PRL   = 4'h3;
    localparam logic [3:0] OFS_PRH   = 4'h4;
    localparam logic [3:0] OFS_PHL   = 4'h5;
    localparam logic [3:0] OFS_PHH   = 4'h6;
    localparam logic [3:0] OFS_DCL   = 4'h7;
    localparam logic [3:0] OFS_DCH   = 4'h8;
    localparam logic [3:0] OFS_RSRC  = 4'h9;
    localparam logic [3:0] OFS_FSRC  = 4'hA;
    localparam logic [3:0] OFS_PSRC  = 4'hB;
    localparam logic [3:0] OFS_FLAGS = 4'hC;

    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_LD_BIT  = 1;
    localparam int FLG_OVF_BIT  = 0;
    localparam int FLG_PRD_BIT  = 1;
    localparam int FLG_PH_BIT   = 2;
    localparam int FLG_DC_BIT   = 3;
    localparam logic [15:0] TMR_RST  = 16'h0000;
    localparam logic [15:0] PR_RST   = 16'hFFFF;
    localparam logic [15:0] PH_RST   = 16'h0000;
    localparam logic [15:0] DC_RST   = 16'h0000;
    localparam logic [5:0]  RSRC_RST = 6'h01;
    localparam logic [5:0]  FSRC_RST = 6'h01;
    localparam logic [5:0]  PSRC_RST = 6'h01;

    // Source vector: bit 0 is the time base match, then pin, then comparators
    typedef struct packed {
        logic [3:0] cmp;
        logic       pin;
        logic       match;
    } src_t;

    typedef struct packed {
        logic dc;
        logic ph;
        logic prd;
        logic ovf;
    } flags_t;

endpackage
`default_nettype wire

// >>> verilog/pwm_event_time_base.sv
// Local design decisions: the plain strobed port and the placing of the registers.
`default_nettype none
module pwm_event_time_base
    import pwm_evt_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic              MCLK_I,
    input  wire logic              RST_N_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [7:0]        WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [7:0]        RDATA_O,
    input  wire logic              EXT_EVENT_I,
    input  wire logic [3:0]        CMP_SYNC_I,
    output logic                   PERIOD_EVENT_O,
    output logic                   RISE_EVENT_O,
    output logic                   FALL_EVENT_O,
    output logic                   RISE_BLANK_START_O,
    output logic                   FALL_BLANK_START_O,
    output logic                   DEADBAND_START_O,
    output logic                   PWM_O
);

    // ---------------------------------------------------------------
    // Elaboration check
    // ---------------------------------------------------------------
    // Byte-pair access and 16-bit constants fix the width
    if (CNT_W != 16) begin : g_bad_width
        $error("CNT_W must be 16");
    end

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    function automatic logic [15:0] put_byte(input logic [15:0] old,
                                             input logic        hi,
                                             input logic [7:0]  b);
        put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
    endfunction

    function automatic logic rise_edge(input logic now, input logic prev);
        rise_edge = now & ~prev;
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [15:0] tmr_r;
    logic [15:0] tmr_nxt;
    logic [15:0] pr_pend_r;
    logic [15:0] ph_pend_r;
    logic [15:0] dc_pend_r;
    logic [15:0] pr_act_r;
    logic [15:0] ph_act_r;
    logic [15:0] dc_act_r;
    logic [5:0]  rsrc_r;
    logic [5:0]  fsrc_r;
    logic [5:0]  psrc_r;
    logic        en_r;
    logic        ld_r;
    logic        ld_nxt;
    flags_t      flags_r;
    flags_t      flags_nxt;
    logic        rise_done_r;
    logic        fall_done_r;
    logic        pin_prev_r;
    logic [3:0]  cmp_prev_r;
    logic        pwm_r;
    logic [7:0]  rdata_r;
    logic        per_ev_r;
    logic        rise_ev_r;
    logic        fall_ev_r;
    logic        rblank_r;
    logic        fblank_r;
    logic        dband_r;

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    wire wr_ctrl  = WR_I && (ADDR_I == OFS_CTRL);
    wire wr_tmrl  = WR_I && (ADDR_I == OFS_TMRL);
    wire wr_tmrh  = WR_I && (ADDR_I == OFS_TMRH);
    wire wr_flags = WR_I && (ADDR_I == OFS_FLAGS);
    wire wr_en_v  = WDATA_I[CTRL_EN_BIT];
    wire disable_now = wr_ctrl && !wr_en_v;

    // ---------------------------------------------------------------
    // Event sources
    // ---------------------------------------------------------------
    // Async inputs are edge triggered, not level sensitive
    wire       pin_edge = rise_edge(EXT_EVENT_I, pin_prev_r);
    wire [3:0] cmp_edge = CMP_SYNC_I & ~cmp_prev_r;

    wire pr_match = (tmr_r == pr_act_r);
    wire ph_match = (tmr_r == ph_act_r);
    wire dc_match = (tmr_r == dc_act_r);

    src_t per_src;
    src_t rise_src;
    src_t fall_src;
    assign per_src  = '{cmp: cmp_edge, pin: pin_edge, match: pr_match};
    assign rise_src = '{cmp: cmp_edge, pin: pin_edge, match: ph_match};
    assign fall_src = '{cmp: cmp_edge, pin: pin_edge, match: dc_match};

    wire per_raw  = en_r && |(psrc_r & per_src);
    wire rise_raw = en_r && |(rsrc_r & rise_src);
    wire fall_raw = en_r && |(fsrc_r & fall_src);

    // ---------------------------------------------------------------
    // Per-period gating
    // ---------------------------------------------------------------
    // Events in the period-event cycle still belong to the ending period
    wire fall_ok = fall_raw && !fall_done_r;
    wire rise_ok = rise_raw && !rise_done_r
                && !fall_done_r;

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    wire wrap = en_r && (tmr_r == 16'hFFFF) && !per_raw;

    always_comb begin
        tmr_nxt = tmr_r;
        if (!en_r) begin
            tmr_nxt = TMR_RST;
        end else if (per_raw) begin
            tmr_nxt = 16'h0000;
        end else begin
            tmr_nxt = tmr_r + 16'h0001;
        end
        if (wr_tmrl) begin
            tmr_nxt = put_byte(tmr_nxt, 1'b0, WDATA_I);
        end
        if (wr_tmrh) begin
            tmr_nxt = put_byte(tmr_nxt, 1'b1, WDATA_I);
        end
        if (disable_now) begin
            tmr_nxt = TMR_RST;
        end
    end

    // ---------------------------------------------------------------
    // Load request and flags
    // ---------------------------------------------------------------
    // A request written in the apply cycle is kept for the next period
    always_comb begin
        ld_nxt = ld_r;
        if (per_raw) begin
            ld_nxt = 1'b0;
        end
        if (wr_ctrl && WDATA_I[CTRL_LD_BIT]) begin
            ld_nxt = 1'b1;
        end
    end

    // Write one to clear; a new event in the same cycle wins
    always_comb begin
        flags_nxt = flags_r;
        if (wr_flags) begin
            flags_nxt = flags_r & ~flags_t'(WDATA_I[3:0]);
        end
        if (wrap) begin
            flags_nxt.ovf = 1'b1;
        end
        if (en_r && pr_match) begin
            flags_nxt.prd = 1'b1;
        end
        if (en_r && ph_match) begin
            flags_nxt.ph = 1'b1;
        end
        if (en_r && dc_match) begin
            flags_nxt.dc = 1'b1;
        end
        if (!en_r) begin
            flags_nxt = '0;
        end
    end

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        case (ADDR_I)
            OFS_CTRL:  rd_mux = {6'h00, ld_r, en_r};
            OFS_TMRL:  rd_mux = tmr_r[7:0];
            OFS_TMRH:  rd_mux = tmr_r[15:8];
            OFS_PRL:   rd_mux = pr_pend_r[7:0];
            OFS_PRH:   rd_mux = pr_pend_r[15:8];
            OFS_PHL:   rd_mux = ph_pend_r[7:0];
            OFS_PHH:   rd_mux = ph_pend_r[15:8];
            OFS_DCL:   rd_mux = dc_pend_r[7:0];
            OFS_DCH:   rd_mux = dc_pend_r[15:8];
            OFS_RSRC:  rd_mux = {2'h0, rsrc_r};
            OFS_FSRC:  rd_mux = {2'h0, fsrc_r};
            OFS_PSRC:  rd_mux = {2'h0, psrc_r};
            OFS_FLAGS: rd_mux = {4'h0, flags_r};
            default:   rd_mux = 8'h00;
        endcase
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            tmr_r   <= TMR_RST;
            ld_r    <= 1'b0;
            en_r    <= 1'b0;
            flags_r <= '0;
            rdata_r <= 8'h00;
        end else begin
            tmr_r   <= tmr_nxt;
            ld_r    <= ld_nxt;
            flags_r <= flags_nxt;
            rdata_r <= RD_I ? rd_mux : 8'h00;
            if (wr_ctrl) begin
                en_r <= wr_en_v;
            end
        end
    end

    // Software only touches pending copies
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            pr_pend_r <= PR_RST;
            ph_pend_r <= PH_RST;
            dc_pend_r <= DC_RST;
            rsrc_r    <= RSRC_RST;
            fsrc_r    <= FSRC_RST;
            psrc_r    <= PSRC_RST;
        end else if (WR_I) begin
            case (ADDR_I)
                OFS_PRL:  pr_pend_r <= put_byte(pr_pend_r, 1'b0, WDATA_I);
                OFS_PRH:  pr_pend_r <= put_byte(pr_pend_r, 1'b1, WDATA_I);
                OFS_PHL:  ph_pend_r <= put_byte(ph_pend_r, 1'b0, WDATA_I);
                OFS_PHH:  ph_pend_r <= put_byte(ph_pend_r, 1'b1, WDATA_I);
                OFS_DCL:  dc_pend_r <= put_byte(dc_pend_r, 1'b0, WDATA_I);
                OFS_DCH:  dc_pend_r <= put_byte(dc_pend_r, 1'b1, WDATA_I);
                OFS_RSRC: rsrc_r <= WDATA_I[5:0];
                OFS_FSRC: fsrc_r <= WDATA_I[5:0];
                OFS_PSRC: psrc_r <= WDATA_I[5:0];
                default:  ;
            endcase
        end
    end

    // Shadows move only together at a period reset
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            pr_act_r <= PR_RST;
            ph_act_r <= PH_RST;
            dc_act_r <= DC_RST;
        end else if (per_raw && ld_r) begin
            pr_act_r <= pr_pend_r;
            ph_act_r <= ph_pend_r;
            dc_act_r <= dc_pend_r;
        end
    end

    // ---------------------------------------------------------------
    // Gating, waveform and start pulses
    // ---------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I || !en_r) begin
            rise_done_r <= 1'b0;
            fall_done_r <= 1'b0;
            pwm_r       <= 1'b0;
            per_ev_r    <= 1'b0;
            rise_ev_r   <= 1'b0;
            fall_ev_r   <= 1'b0;
            rblank_r    <= 1'b0;
            fblank_r    <= 1'b0;
            dband_r     <= 1'b0;
        end else begin
            rise_done_r <= !per_raw && (rise_done_r || rise_ok);
            fall_done_r <= !per_raw && (fall_done_r || fall_ok);
            // Falling wins a tie, so equal phase and duty never drive high
            if (fall_ok) begin
                pwm_r <= 1'b0;
            end else if (rise_ok) begin
                pwm_r <= 1'b1;
            end
            per_ev_r  <= per_raw;
            rise_ev_r <= rise_ok;
            fall_ev_r <= fall_ok;
            fblank_r  <= rise_ok;
            rblank_r  <= fall_ok;
            dband_r   <= rise_ok || fall_ok;
        end
    end

    // Sampling history, not a synchroniser: inputs are already synchronous
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            pin_prev_r <= 1'b0;
            cmp_prev_r <= 4'h0;
        end else begin
            pin_prev_r <= EXT_EVENT_I;
            cmp_prev_r <= CMP_SYNC_I;
        end
    end

    assign RDATA_O            = rdata_r;
    assign PERIOD_EVENT_O     = per_ev_r;
    assign RISE_EVENT_O       = rise_ev_r;
    assign FALL_EVENT_O       = fall_ev_r;
    assign RISE_BLANK_START_O = rblank_r;
    assign FALL_BLANK_START_O = fblank_r;
    assign DEADBAND_START_O   = dband_r;
    assign PWM_O              = pwm_r;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_second_rise;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (rise_ev_r && !per_ev_r && en_r && !per_raw) ##1 !per_raw
        |=> !rise_ev_r;
    endproperty
    a_second_rise: assert property (p_second_rise)
        else $error("second rising event in one period");

    property p_rise_after_fall;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        fall_done_r && !per_raw |=> !rise_ev_r;
    endproperty
    a_rise_after_fall: assert property (p_rise_after_fall)
        else $error("rising event after falling event");

    property p_fall_once;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        fall_done_r && !per_raw |=> !fall_ev_r;
    endproperty
    a_fall_once: assert property (p_fall_once)
        else $error("second falling event in one period");

    property p_starts;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        en_r && rise_ok |=> fblank_r && dband_r;
    endproperty
    a_starts: assert property (p_starts)
        else $error("rising event did not start timers");

    property p_fstarts;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        en_r && fall_ok |=> rblank_r && dband_r && !pwm_r;
    endproperty
    a_fstarts: assert property (p_fstarts)
        else $error("falling event did not start timers");

    property p_period_reset;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        en_r && per_raw && !WR_I |=> tmr_r == 16'h0000
            ##1 (tmr_r == 16'h0001 || $past(per_raw) || !en_r || $past(WR_I));
    endproperty
    a_period_reset: assert property (p_period_reset)
        else $error("counter did not restart after period event");

    property p_load;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        per_raw && ld_r |=> pr_act_r == $past(pr_pend_r)
            && ph_act_r == $past(ph_pend_r)
            && dc_act_r == $past(dc_pend_r)
            && (!ld_r || $past(wr_ctrl));
    endproperty
    a_load: assert property (p_load)
        else $error("pending values not applied");

    property p_hold;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        !per_raw |=> $stable(pr_act_r) && $stable(ph_act_r)
            && $stable(dc_act_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("shadow changed outside period reset");

    property p_ovf;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        wrap && !wr_ctrl && !wr_tmrl && !wr_tmrh
            |=> flags_r.ovf && tmr_r == 16'h0000;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow flag not set on wrap");

    property p_disable;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        !en_r && !WR_I |=> tmr_r == TMR_RST && flags_r == '0;
    endproperty
    a_disable: assert property (p_disable)
        else $error("counter not reset while disabled");

endmodule
`default_nettype wire
